// >>> include/pll_tick_pkg.sv
// constants and types shared by the pll control and tick divider logic
package pll_tick_pkg;

    // ************************************************************
    // register map and widths
    // ************************************************************
    localparam int        ADDR_W         = 2;
    localparam int        DATA_W         = 8;
    localparam int        TICK_CNT_W     = 21;
    localparam logic [1:0] ADDR_PLL_CTRL  = 2'h0;
    localparam logic [1:0] ADDR_TICK_CTRL = 2'h1;
    localparam logic [1:0] ADDR_STATUS    = 2'h2;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int BIT_MON_EN   = 7;
    localparam int BIT_PLL_ON   = 6;
    localparam int BIT_AUTO     = 5;
    localparam int BIT_MAN_HB   = 4;
    localparam int BIT_PRE      = 2;
    localparam int BIT_WDOG_PS  = 1;
    localparam int BIT_SELF_EN  = 0;
    localparam int RATE_PRE_MSB = 6;
    localparam int RATE_PRE_LSB = 4;
    localparam int RATE_MOD_MSB = 3;
    localparam int RATE_MOD_LSB = 0;
    localparam int STAT_SELF    = 0;
    localparam int STAT_ARMED   = 1;
    localparam int STAT_ONCE    = 2;

    // ************************************************************
    // reset values and encodings
    // ************************************************************
    localparam logic [7:0] PLL_CTRL_RST  = 8'h00;
    localparam logic [7:0] TICK_CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_ZERO     = 8'h00;
    localparam logic [2:0] PRESCALE_OFF  = 3'h0;
    localparam logic [4:0] PRESCALE_BASE = 5'h09;
    localparam logic [TICK_CNT_W-1:0] CNT_ZERO = 21'h00_0000;
    localparam logic [TICK_CNT_W-1:0] CNT_ONE  = 21'h00_0001;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        ST_NORMAL = 2'b01,
        ST_SELF   = 2'b10
    } clock_state_t;

    typedef struct packed {
        logic             wr;
        logic             rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic stop;
        logic wait_m;
        logic special;
        logic pseudo_stop_select;
        logic pll_stop_in_wait;
        logic pll_clock_select;
        logic tick_stop_in_wait;
    } mode_t;

endpackage : pll_tick_pkg

// >>> rtl/tick_divider.sv
// modulus counter that divides the oscillator enable into tick events
`timescale 1ns/10ps
module tick_divider #(
    parameter int CNT_W = 21
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             run,
    input  wire logic             clear,
    input  wire logic [CNT_W-1:0] limit,
    output logic                  tick
);

    logic [CNT_W-1:0] cnt_q;
    logic             wrap;

    assign wrap = (cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}) >= limit;

    // ************************************************************
    // counter
    // ************************************************************
    // count and restart
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= '0;
        else if (clear || limit == '0)
            cnt_q <= '0;
        else if (run)
            cnt_q <= wrap ? '0 : cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tick <= 1'b0;
        else
            tick <= run && !clear && limit != '0 && wrap;
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_clear_restarts: assert property (@(posedge clk) disable iff (!rst_n)
        clear |=> cnt_q == '0)
        else $error("divider count not cleared");

    a_hold_frozen: assert property (@(posedge clk) disable iff (!rst_n)
        (!run && !clear && limit != '0) |=> cnt_q == $past(cnt_q))
        else $error("divider count moved while frozen");

endmodule : tick_divider

// >>> rtl/pll_tick_ctrl.sv
// pll control register, self clock mode control and periodic tick divider
`timescale 1ns/10ps
// Function
// - monitor enable locked while self clocking
// - enabled monitor turns clock failure into action
// - full stop disables the monitor
// - pll power bit locked while pll selected
// - self clocking forces pll on, bit unchanged
// - auto bandwidth follows frequency error
// - stop in wait holds auto at one
// - manual bandwidth bit always writable
// - tick runs in pseudo stop if enabled
// - watchdog runs in pseudo stop if enabled
// - self clock enable write once outside special mode, no clear in self clock
// - failure enters self clock or resets
// - tick control write restarts counter
// - prescale code picks power of two
// - modulus multiplies prescale by value plus one
// - tick counts oscillator clock only
// - prescale resets to off
// - pseudo stop keeps oscillator at low amplitude
// - stop in wait clears select, powers pll down
module pll_tick_ctrl (
    input  wire logic                           sys_clk,
    input  wire logic                           nrst,
    input  wire pll_tick_pkg::bus_req_t         bus_req,
    output logic [pll_tick_pkg::DATA_W-1:0]     bus_rdata,
    input  wire pll_tick_pkg::mode_t            mode,
    input  wire logic                           oscillator_clock,
    input  wire logic                           osc_fail,
    input  wire logic                           pll_freq_far,
    output logic                                pll_power,
    output logic                                high_bandwidth,
    output logic                                pll_select_clear,
    output logic                                self_clock_active,
    output logic                                monitor_reset,
    output logic                                osc_run,
    output logic                                osc_low_amp,
    output logic                                watchdog_run,
    output logic                                periodic_tick
);

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ************************************************************
    // register state
    // ************************************************************
    logic                          mon_en_q;
    logic                          pll_power_on_q;
    logic                          auto_q;
    logic                          manual_high_bandwidth_q;
    logic                          pre_q;
    logic                          watchdog_run_in_pseudo_stop_q;
    logic                          self_en_q;
    logic                          self_en_written_q;
    logic [7:0]                    tick_control_q;
    logic                          fail_q;
    pll_tick_pkg::clock_state_t    state_q;
    logic                          self_mode;
    logic                          wr_pll;
    logic                          wr_tick;
    logic                          pseudo_stop;
    logic                          full_stop;
    logic [2:0]                    prescale;
    logic [3:0]                    modulus;
    logic [pll_tick_pkg::TICK_CNT_W-1:0] tick_limit;
    logic                          tick_run;
    logic                          tick_clear;
    logic [7:0]                    pll_read;
    logic [7:0]                    status_read;

    assign self_mode   = state_q == pll_tick_pkg::ST_SELF;
    assign wr_pll      = bus_req.wr && bus_req.addr == pll_tick_pkg::ADDR_PLL_CTRL;
    assign wr_tick     = bus_req.wr && bus_req.addr == pll_tick_pkg::ADDR_TICK_CTRL;
    assign pseudo_stop = mode.stop && mode.pseudo_stop_select;
    assign full_stop   = mode.stop && !mode.pseudo_stop_select;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            mon_en_q <= pll_tick_pkg::PLL_CTRL_RST[pll_tick_pkg::BIT_MON_EN];
        else if (wr_pll && !self_mode)
            mon_en_q <= bus_req.wdata[pll_tick_pkg::BIT_MON_EN];
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            pll_power_on_q <= pll_tick_pkg::PLL_CTRL_RST[pll_tick_pkg::BIT_PLL_ON];
        else if (wr_pll && !mode.pll_clock_select)
            pll_power_on_q <= bus_req.wdata[pll_tick_pkg::BIT_PLL_ON];
    end

    // auto held while stop in wait
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            auto_q <= pll_tick_pkg::PLL_CTRL_RST[pll_tick_pkg::BIT_AUTO];
        else if (mode.pll_stop_in_wait)
            auto_q <= 1'b1;
        else if (wr_pll)
            auto_q <= bus_req.wdata[pll_tick_pkg::BIT_AUTO];
    end

    // manual bandwidth and pseudo stop enables
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            manual_high_bandwidth_q       <= pll_tick_pkg::PLL_CTRL_RST[pll_tick_pkg::BIT_MAN_HB];
            pre_q                         <= pll_tick_pkg::PLL_CTRL_RST[pll_tick_pkg::BIT_PRE];
            watchdog_run_in_pseudo_stop_q <= pll_tick_pkg::PLL_CTRL_RST[pll_tick_pkg::BIT_WDOG_PS];
        end
        else if (wr_pll)
        begin
            manual_high_bandwidth_q       <= bus_req.wdata[pll_tick_pkg::BIT_MAN_HB];
            pre_q                         <= bus_req.wdata[pll_tick_pkg::BIT_PRE];
            watchdog_run_in_pseudo_stop_q <= bus_req.wdata[pll_tick_pkg::BIT_WDOG_PS];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            self_en_q         <= pll_tick_pkg::PLL_CTRL_RST[pll_tick_pkg::BIT_SELF_EN];
            self_en_written_q <= 1'b0;
        end
        else if (wr_pll && (mode.special || !self_en_written_q))
        begin
            self_en_written_q <= 1'b1;
            if (!(self_mode && !bus_req.wdata[pll_tick_pkg::BIT_SELF_EN]))
                self_en_q <= bus_req.wdata[pll_tick_pkg::BIT_SELF_EN];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            tick_control_q <= pll_tick_pkg::TICK_CTRL_RST;
        else if (wr_tick)
            tick_control_q <= bus_req.wdata;
    end

    // ************************************************************
    // clock monitor and self clock mode
    // ************************************************************
    // failure detection gate
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            fail_q <= 1'b0;
        else
            fail_q <= osc_fail && mon_en_q && !full_stop;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q       <= pll_tick_pkg::ST_NORMAL;
            monitor_reset <= 1'b0;
        end
        else
        begin
            monitor_reset <= fail_q && !self_en_q;
            unique case (state_q)
                pll_tick_pkg::ST_NORMAL:
                    if (fail_q && self_en_q)
                        state_q <= pll_tick_pkg::ST_SELF;
                pll_tick_pkg::ST_SELF:
                    state_q <= pll_tick_pkg::ST_SELF;
                default:
                    state_q <= pll_tick_pkg::ST_NORMAL;
            endcase
        end
    end

    // ************************************************************
    // pll and oscillator outputs
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pll_power         <= 1'b0;
            high_bandwidth    <= 1'b0;
            pll_select_clear  <= 1'b0;
            self_clock_active <= 1'b0;
            osc_run           <= 1'b1;
            osc_low_amp       <= 1'b0;
            watchdog_run      <= 1'b1;
        end
        else
        begin
            // forced on in self clock, powered down in wait when pll stop in wait is set
            pll_power         <= self_mode || (pll_power_on_q && !(mode.wait_m && mode.pll_stop_in_wait));
            high_bandwidth    <= auto_q ? pll_freq_far : manual_high_bandwidth_q;
            pll_select_clear  <= mode.wait_m && mode.pll_stop_in_wait;
            self_clock_active <= self_mode;
            osc_run           <= !full_stop;
            osc_low_amp       <= pseudo_stop;
            watchdog_run      <= !full_stop && !(pseudo_stop && !watchdog_run_in_pseudo_stop_q);
        end
    end

    // ************************************************************
    // tick divider
    // ************************************************************
    assign prescale = tick_control_q[pll_tick_pkg::RATE_PRE_MSB:pll_tick_pkg::RATE_PRE_LSB];
    assign modulus  = tick_control_q[pll_tick_pkg::RATE_MOD_MSB:pll_tick_pkg::RATE_MOD_LSB];

    always_comb
    begin
        tick_limit = pll_tick_pkg::CNT_ZERO;
        if (prescale != pll_tick_pkg::PRESCALE_OFF)
            tick_limit = (pll_tick_pkg::TICK_CNT_W'(modulus) + pll_tick_pkg::CNT_ONE)
                         << (5'(prescale) + pll_tick_pkg::PRESCALE_BASE);
    end

    assign tick_run   = oscillator_clock && !full_stop && !(pseudo_stop && !pre_q);
    assign tick_clear = wr_tick || (mode.wait_m && mode.tick_stop_in_wait);

    tick_divider #(
        .CNT_W (pll_tick_pkg::TICK_CNT_W)
    ) u_tick (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .run   (tick_run),
        .clear (tick_clear),
        .limit (tick_limit),
        .tick  (periodic_tick)
    );

    // ************************************************************
    // register reads
    // ************************************************************
    assign pll_read = {mon_en_q, pll_power_on_q, auto_q, manual_high_bandwidth_q, 1'b0,
                       pre_q, watchdog_run_in_pseudo_stop_q, self_en_q};
    assign status_read = {5'h00, self_en_written_q, mon_en_q && !full_stop, self_mode};

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            bus_rdata <= pll_tick_pkg::DATA_ZERO;
        else if (bus_req.rd)
        begin
            unique case (bus_req.addr)
                pll_tick_pkg::ADDR_PLL_CTRL:  bus_rdata <= pll_read;
                pll_tick_pkg::ADDR_TICK_CTRL: bus_rdata <= tick_control_q;
                pll_tick_pkg::ADDR_STATUS:    bus_rdata <= status_read;
                default:                      bus_rdata <= pll_tick_pkg::DATA_ZERO;
            endcase
        end
        else
            bus_rdata <= pll_tick_pkg::DATA_ZERO;
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_fail_seen;
        fail_q && self_en_q && !self_mode;
    endsequence

    sequence s_tick_off_2;
        (prescale == pll_tick_pkg::PRESCALE_OFF) [*2];
    endsequence

    a_mon_en_locked: assert property (wr_pll && self_mode |=> mon_en_q == $past(mon_en_q))
        else $error("monitor enable changed in self clock");

    a_no_detect_off: assert property (osc_fail && !mon_en_q |=> !fail_q)
        else $error("failure seen with monitor off");

    a_full_stop_blind: assert property (osc_fail && full_stop |=> !fail_q)
        else $error("failure seen in full stop");

    a_pll_on_locked: assert property (wr_pll && mode.pll_clock_select |=> pll_power_on_q == $past(pll_power_on_q))
        else $error("pll power bit changed while selected");

    a_self_forces_pll: assert property (self_mode |=> pll_power)
        else $error("pll not forced on in self clock");

    a_auto_band: assert property (auto_q |=> high_bandwidth == $past(pll_freq_far))
        else $error("auto bandwidth ignored frequency error");

    a_auto_held: assert property (mode.pll_stop_in_wait |=> auto_q)
        else $error("auto not held in stop in wait");

    a_self_en_kept: assert property (self_mode && self_en_q |=> self_en_q)
        else $error("self clock enable cleared in self clock");

    a_fail_enters_self: assert property (s_fail_seen |=> self_mode ##0 !monitor_reset)
        else $error("failure did not enter self clock");

    a_fail_resets: assert property (fail_q && !self_en_q |=> monitor_reset && !self_mode)
        else $error("failure did not raise monitor reset");

    a_tick_off: assert property (s_tick_off_2 |-> !periodic_tick)
        else $error("tick while prescale off");

    a_read_latency: assert property (bus_req.rd && bus_req.addr == pll_tick_pkg::ADDR_TICK_CTRL && !wr_tick
                                     |=> bus_rdata == $past(tick_control_q))
        else $error("tick control read mismatch");

endmodule : pll_tick_ctrl

// >>> testbench/testbench.sv
// self-checking bench for the pll control and tick divider block
`timescale 1ns/10ps
module testbench;
    // ************************************************************
    // signals and design instance
    // ************************************************************
    logic                          sys_clk;
    logic                          nrst;
    pll_tick_pkg::bus_req_t        req;
    logic [7:0]                    bus_rdata;
    pll_tick_pkg::mode_t           mode;
    logic                          osc_q;
    logic                          osc_half;
    logic                          osc_fail;
    logic                          pll_freq_far;
    logic                          pll_power;
    logic                          high_bandwidth;
    logic                          pll_select_clear;
    logic                          self_clock_active;
    logic                          monitor_reset;
    logic                          osc_run;
    logic                          osc_low_amp;
    logic                          watchdog_run;
    logic                          periodic_tick;
    int                            n_errors;
    int                            checked;
    logic [7:0]                    rd_val;
    int                            n;

    pll_tick_ctrl u_pll_tick_ctrl (
        .sys_clk           (sys_clk),
        .nrst              (nrst),
        .bus_req           (req),
        .bus_rdata         (bus_rdata),
        .mode              (mode),
        .oscillator_clock  (osc_q),
        .osc_fail          (osc_fail),
        .pll_freq_far      (pll_freq_far),
        .pll_power         (pll_power),
        .high_bandwidth    (high_bandwidth),
        .pll_select_clear  (pll_select_clear),
        .self_clock_active (self_clock_active),
        .monitor_reset     (monitor_reset),
        .osc_run           (osc_run),
        .osc_low_amp       (osc_low_amp),
        .watchdog_run      (watchdog_run),
        .periodic_tick     (periodic_tick)
    );

    // ************************************************************
    // clock, oscillator enable and helpers
    // ************************************************************
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
        osc_q <= osc_half ? ~osc_q : 1'b1;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic do_reset();
        nrst     <= 1'b0;
        req      <= '0;
        mode     <= '0;
        osc_fail <= 1'b0;
        osc_half <= 1'b0;
        pll_freq_far <= 1'b0;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask : do_reset

    task automatic bus_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= d;
        @(posedge sys_clk);
        req <= '0;
    endtask : bus_write

    task automatic rd_chk(input string what, input logic [1:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        req.rd   <= 1'b1;
        req.addr <= a;
        @(posedge sys_clk);
        req <= '0;
        #1;
        check(what, bus_rdata, exp);
    endtask : rd_chk

    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic wait_tick(input int limit, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end while (periodic_tick !== 1'b1 && cnt < limit);
    endtask : wait_tick

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset_values();
        do_reset();
        rd_chk("pll_control reset", 2'h0, 8'h00);
        rd_chk("tick_control reset", 2'h1, 8'h00);
        rd_chk("unmapped read", 2'h3, 8'h00);
        check("osc_run reset", osc_run, 1'b1);
    endtask : t_reset_values

    task automatic t_bandwidth();
        do_reset();
        bus_write(2'h0, 8'h18);
        rd_chk("bit3 reads zero", 2'h0, 8'h10);
        settle();
        check("manual high bw", high_bandwidth, 1'b1);
        bus_write(2'h0, 8'h30);
        settle();
        check("auto bw near", high_bandwidth, 1'b0);
        pll_freq_far <= 1'b1;
        settle();
        check("auto bw far", high_bandwidth, 1'b1);
        mode.pll_stop_in_wait <= 1'b1;
        bus_write(2'h0, 8'h00);
        rd_chk("auto held", 2'h0, 8'h20);
        mode.wait_m <= 1'b1;
        settle();
        check("select clear", pll_select_clear, 1'b1);
    endtask : t_bandwidth

    task automatic t_power_lock();
        do_reset();
        bus_write(2'h0, 8'h40);
        settle();
        check("pll on", pll_power, 1'b1);
        mode.pll_clock_select <= 1'b1;
        bus_write(2'h0, 8'h00);
        rd_chk("power locked", 2'h0, 8'h40);
        mode.pll_clock_select <= 1'b0;
        bus_write(2'h0, 8'h00);
        settle();
        check("pll off", pll_power, 1'b0);
    endtask : t_power_lock

    task automatic t_monitor();
        do_reset();
        bus_write(2'h0, 8'h80);
        mode.stop <= 1'b1;
        osc_fail  <= 1'b1;
        n = 0;
        repeat (10) @(posedge sys_clk) n += int'(monitor_reset === 1'b1);
        check("no reset in full stop", n, 0);
        mode.stop <= 1'b0;
        n = 0;
        repeat (6) @(posedge sys_clk) n += int'(monitor_reset === 1'b1);
        check("monitor reset raised", n > 0, 1'b1);
        check("no self clock", self_clock_active, 1'b0);
        osc_fail <= 1'b0;
        bus_write(2'h0, 8'h00);
        osc_fail <= 1'b1;
        n = 0;
        repeat (10) @(posedge sys_clk) n += int'(monitor_reset === 1'b1);
        check("monitor off", n, 0);
    endtask : t_monitor

    task automatic t_self_clock();
        do_reset();
        bus_write(2'h0, 8'h00);
        bus_write(2'h0, 8'h01);
        rd_chk("self enable write once", 2'h0, 8'h00);
        do_reset();
        mode.special <= 1'b1;
        bus_write(2'h0, 8'h01);
        bus_write(2'h0, 8'h00);
        rd_chk("self enable special", 2'h0, 8'h00);
        do_reset();
        bus_write(2'h0, 8'h81);
        osc_fail <= 1'b1;
        n = 0;
        repeat (6) @(posedge sys_clk) n += int'(monitor_reset === 1'b1);
        #1;
        check("self clock entered", self_clock_active, 1'b1);
        check("no monitor reset", n, 0);
        check("pll forced on", pll_power, 1'b1);
        bus_write(2'h0, 8'h00);
        rd_chk("enables kept", 2'h0, 8'h81);
    endtask : t_self_clock

    task automatic t_tick();
        do_reset();
        bus_write(2'h1, 8'h00);
        wait_tick(3000, n);
        check("tick off", n, 3000);
        bus_write(2'h1, 8'h10);
        rd_chk("tick readback", 2'h1, 8'h10);
        wait_tick(3000, n);
        wait_tick(3000, n);
        check("period 1024", n, 1024);
        bus_write(2'h1, 8'h21);
        wait_tick(9000, n);
        wait_tick(9000, n);
        check("period 4096", n, 4096);
        bus_write(2'h1, 8'h10);
        osc_half <= 1'b1;
        wait_tick(5000, n);
        wait_tick(5000, n);
        check("period on half osc", n, 2048);
        osc_half <= 1'b0;
        wait_tick(5000, n);
        repeat (400) @(posedge sys_clk);
        bus_write(2'h1, 8'h10);
        wait_tick(3000, n);
        check("restart on write", n >= 1023 && n <= 1026, 1'b1);
        repeat (299) @(posedge sys_clk);
        mode.stop <= 1'b1;
        mode.pseudo_stop_select <= 1'b1;
        settle();
        check("low amplitude", osc_low_amp, 1'b1);
        check("watchdog frozen", watchdog_run, 1'b0);
        repeat (497) @(posedge sys_clk);
        mode <= '0;
        wait_tick(3000, n);
        check("count held", n >= 722 && n <= 726, 1'b1);
        bus_write(2'h0, 8'h06);
        wait_tick(3000, n);
        mode.stop <= 1'b1;
        mode.pseudo_stop_select <= 1'b1;
        wait_tick(3000, n);
        check("tick runs pseudo", n, 1024);
        check("watchdog runs", watchdog_run, 1'b1);
        mode.pseudo_stop_select <= 1'b0;
        settle();
        check("osc off full stop", osc_run, 1'b0);
        mode <= 7'h21;
        wait_tick(3000, n);
        check("tick reinit in wait", n, 3000);
    endtask : t_tick

    // ************************************************************
    // run control
    // ************************************************************
    task automatic wrap_up();
        if (n_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    initial
    begin
        n_errors = 0;
        checked  = 0;
        osc_q    = 1'b0;
        nrst     = 1'b0;
        req      = '0;
        mode     = '0;
        osc_fail = 1'b0;
        osc_half = 1'b0;
        pll_freq_far = 1'b0;
        t_reset_values();
        t_bandwidth();
        t_power_lock();
        t_monitor();
        t_self_clock();
        t_tick();
        wrap_up();
    end

    initial
    begin
        repeat (100000) @(posedge sys_clk);
        n_errors++;
        wrap_up();
    end
endmodule : testbench
